// File: rtl/ethlcs_pkg.sv
// Constants, field positions and reset values of the line control and
// line status logic. Assumes a 200 MHz controller clock.
package ethlcs_pkg;

  // ********************************************************************
  // Register map.
  // ********************************************************************
  localparam logic [11:0] LINE_CONFIG_OFFSET = 12'h112;
  localparam logic [11:0] LINE_STATUS_OFFSET = 12'h134;
  localparam logic [15:0] LINE_CONFIG_RESET = 16'h0013;
  localparam logic [15:0] LINE_STATUS_RESET = 16'h0014;
  localparam logic [5:0] LINE_CONFIG_ID = 6'h13;
  localparam logic [5:0] LINE_STATUS_ID = 6'h14;

  // ********************************************************************
  // Configuration fields.
  // ********************************************************************
  localparam int CFG_RX_ENABLE = 6;
  localparam int CFG_TX_ENABLE = 7;
  localparam int CFG_AUI_ONLY = 8;
  localparam int CFG_AUTO_PORT = 9;
  localparam int CFG_MOD_BACKOFF = 11;
  localparam int CFG_POL_FIX_DIS = 12;
  localparam int CFG_DEFER_DIS = 13;
  localparam int CFG_LOW_SQUELCH = 14;
  localparam int CFG_ID_W = 6;

  // ********************************************************************
  // Status fields.
  // ********************************************************************
  localparam int STS_LINK_GOOD = 7;
  localparam int STS_AUI = 8;
  localparam int STS_TP = 9;
  localparam int STS_POL_OK = 12;
  localparam int STS_CRS = 14;

  // ********************************************************************
  // Timing.
  // ********************************************************************
  localparam int CLK_PERIOD_NS = 5;
  localparam int CRS_HOLD_MIN_NS = 130;
  localparam int CRS_HOLD_CYCLES = (CRS_HOLD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LINK_FAIL_NS = 50000000;
  localparam int LINK_FAIL_CYCLES = LINK_FAIL_NS / CLK_PERIOD_NS;
  localparam int CRS_CNT_W = 6;

  // Frame gate state, one per direction.
  typedef enum logic {
    ETHLCS_GATE_IDLE = 1'b0,
    ETHLCS_GATE_BUSY = 1'b1
  } ethlcs_gate_t;

endpackage

// File: rtl/ethlcs_sync.sv
// Three-stage input synchroniser for pins from outside the clock domain.
// Assumes nothing about the input but that it is a level.
`timescale 1ns/10ps
`default_nettype none
module ethlcs_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Pin side.
  input wire logic [WIDTH-1:0] pin_in,
  // Clock domain side.
  output logic [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;
  logic [WIDTH-1:0] stage3_ff;
  logic [WIDTH-1:0] level_ff;
  logic [WIDTH-1:0] nxt_level;

  // A change is accepted only when stages two and three agree.
  // Stage one feeds stage two alone, to keep metastability contained.
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_comb begin
        nxt_level[i] = (stage2_ff[i] == stage3_ff[i]) ? stage3_ff[i] : level_ff[i];
      end
    end
  endgenerate

  // Register the stages.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1_ff <= '0;
      stage2_ff <= '0;
      stage3_ff <= '0;
      level_ff <= '0;
    end else begin
      stage1_ff <= pin_in;
      stage2_ff <= stage1_ff;
      stage3_ff <= stage2_ff;
      level_ff <= nxt_level;
    end
  end

  assign level_out = level_ff;

endmodule
`default_nettype wire

// File: rtl/ethlcs_link_timer.sv
// Link integrity timer: the link is good while activity keeps arriving.
// Assumes activity is a same-clock pulse or level.
`timescale 1ns/10ps
`default_nettype none
module ethlcs_link_timer #(
  parameter int FAIL_CYCLES = ethlcs_pkg::LINK_FAIL_CYCLES
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Activity seen on the receive pair.
  input wire logic activity,
  // Link state.
  output logic link_good
);

  localparam int CW = $clog2(FAIL_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(FAIL_CYCLES - 1);

  logic [CW-1:0] quiet_ff;
  logic [CW-1:0] nxt_quiet;
  logic good_ff;
  logic nxt_good;

  // Activity restarts the quiet count; a full quiet span fails the link.
  always_comb begin
    nxt_quiet = quiet_ff;
    nxt_good = good_ff;
    if (activity) begin
      nxt_quiet = '0;
      nxt_good = 1'b1;
    end else if (quiet_ff == LAST) begin
      nxt_good = 1'b0;
    end else begin
      nxt_quiet = quiet_ff + CW'(1);
    end
  end

  // Register the timer; the link starts failed out of reset.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      quiet_ff <= '0;
      good_ff <= 1'b0;
    end else begin
      quiet_ff <= nxt_quiet;
      good_ff <= nxt_good;
    end
  end

  assign link_good = good_ff;

endmodule
`default_nettype wire

// File: rtl/ethlcs_top.sv
// Line configuration and line status logic of a 10 Mb/s controller.
// Assumes a same-clock register port and a MAC that frames transfers
// with start and end pulses; analogue pins are synchronised here.
//
// Behaviour
// - Transmission may start only while the transmit enable bit is set.
// - Clearing transmit enable mid-frame finishes that frame, then stops.
// - Receive passes frames only while enabled; a running frame completes.
// - Modified backoff bit lengthens backoff after first three collisions.
// - Polarity fix disable clear inverts reversed receive polarity; set, none.
// - Polarity status shows true incoming polarity regardless of correction.
// - Deferral disable bit skips the two-part deferral when set.
// - Low squelch bit lowers receive squelch thresholds about 6dB.
// - Config resets to 0x0013; an EEPROM may load it instead.
// - Status low six bits always read 010100.
// - Link good clears at reset and after 50 ms quiet.
// - Two status bits show AUI or twisted pair in use.
// - Carrier sense falls 1.3 to 2.3 bit times after last rise.
// - Status resets to 0x0014 with all flags clear.
`timescale 1ns/10ps
`default_nettype none
module ethlcs_top #(
  parameter int LINK_FAIL_CYCLES = ethlcs_pkg::LINK_FAIL_CYCLES
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Register port.
  input wire logic [11:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  // Configuration load from the EEPROM reader.
  input wire logic eeprom_load,
  input wire logic [15:0] eeprom_config,
  // Transmit MAC handshake.
  input wire logic tx_request,
  input wire logic tx_frame_end,
  output logic tx_grant,
  output logic tx_busy,
  // Receive MAC handshake.
  output logic rx_pass,
  // Pins from the analogue front end.
  input wire logic rx_data_pin,
  input wire logic link_pulse_pin,
  input wire logic rx_pol_reversed_pin,
  // Controls to the MAC and front end.
  output logic rx_data,
  output logic rx_invert,
  output logic modified_backoff_enable,
  output logic two_part_defer_disable,
  output logic low_squelch_select,
  output logic aui_in_use,
  output logic twisted_pair_in_use,
  output logic tp_tx_enable
);

  // ********************************************************************
  // Pin synchronisers.
  // ********************************************************************
  logic rx_raw;
  logic link_pulse;
  logic pol_reversed;

  ethlcs_sync #(
    .WIDTH(3)
  ) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .pin_in({rx_pol_reversed_pin, link_pulse_pin, rx_data_pin}),
    .level_out({pol_reversed, link_pulse, rx_raw})
  );

  // ********************************************************************
  // Line configuration register.
  // ********************************************************************
  logic [15:0] config_ff;
  logic [15:0] nxt_config;
  logic transmit_enable_bit;
  logic receive_enable_bit;
  logic attachment_only_select;
  logic automatic_port_select;
  logic polarity_fix_disable;
  logic cfg_hit;
  logic sts_hit;
  assign cfg_hit = (reg_addr == ethlcs_pkg::LINE_CONFIG_OFFSET);
  assign sts_hit = (reg_addr == ethlcs_pkg::LINE_STATUS_OFFSET);
  // A host write beats an EEPROM load in the same cycle; identity bits stay.
  // eeprom load
  always_comb begin
    nxt_config = config_ff;
    if (eeprom_load) begin
      nxt_config = eeprom_config;
    end
    if (reg_wr && cfg_hit) begin
      nxt_config = reg_wdata;
    end
    nxt_config[ethlcs_pkg::CFG_ID_W-1:0] = ethlcs_pkg::LINE_CONFIG_ID;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      config_ff <= ethlcs_pkg::LINE_CONFIG_RESET;
    end else begin
      config_ff <= nxt_config;
    end
  end

  assign transmit_enable_bit = config_ff[ethlcs_pkg::CFG_TX_ENABLE];
  assign receive_enable_bit = config_ff[ethlcs_pkg::CFG_RX_ENABLE];
  assign attachment_only_select = config_ff[ethlcs_pkg::CFG_AUI_ONLY];
  assign automatic_port_select = config_ff[ethlcs_pkg::CFG_AUTO_PORT];
  assign polarity_fix_disable = config_ff[ethlcs_pkg::CFG_POL_FIX_DIS];

  // Plain control levels handed to the MAC and the front end.
  // backoff choice
  assign modified_backoff_enable = config_ff[ethlcs_pkg::CFG_MOD_BACKOFF];
  assign two_part_defer_disable = config_ff[ethlcs_pkg::CFG_DEFER_DIS];
  assign low_squelch_select = config_ff[ethlcs_pkg::CFG_LOW_SQUELCH];

  // ********************************************************************
  // Receive polarity and carrier sense.
  // ********************************************************************
  logic carrier_ff;
  logic nxt_carrier;
  logic rx_prev_ff;
  logic [ethlcs_pkg::CRS_CNT_W-1:0] hold_ff;
  logic [ethlcs_pkg::CRS_CNT_W-1:0] nxt_hold;
  logic rx_rise;
  logic rx_data_ff;
  localparam logic [ethlcs_pkg::CRS_CNT_W-1:0] HOLD_LAST =
    ethlcs_pkg::CRS_CNT_W'(ethlcs_pkg::CRS_HOLD_CYCLES - 1);
  assign rx_invert = pol_reversed & ~polarity_fix_disable;
  assign rx_rise = rx_data_ff & ~rx_prev_ff;

  // Carrier rises on a data rise and falls a fixed hold after the last one;
  // the hold is the shortest allowed, so synchroniser delay stays in window.
  // carrier hold
  always_comb begin
    nxt_carrier = carrier_ff;
    nxt_hold = hold_ff;
    if (rx_rise) begin
      nxt_carrier = 1'b1;
      nxt_hold = '0;
    end else if (carrier_ff) begin
      if (hold_ff == HOLD_LAST) begin
        nxt_carrier = 1'b0;
      end else begin
        nxt_hold = hold_ff + ethlcs_pkg::CRS_CNT_W'(1);
      end
    end
  end

  // Register the corrected data and the carrier state.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_data_ff <= 1'b0;
      rx_prev_ff <= 1'b0;
      carrier_ff <= 1'b0;
      hold_ff <= '0;
    end else begin
      rx_data_ff <= rx_raw ^ rx_invert;
      rx_prev_ff <= rx_data_ff;
      carrier_ff <= nxt_carrier;
      hold_ff <= nxt_hold;
    end
  end

  assign rx_data = rx_data_ff;

  // ********************************************************************
  // Link integrity and port choice.
  // ********************************************************************
  logic link_good_flag;
  ethlcs_link_timer #(
    .FAIL_CYCLES(LINK_FAIL_CYCLES)
  ) u_link (
    .clk(clk),
    .rst_b(rst_b),
    .activity(link_pulse | carrier_ff),
    .link_good(link_good_flag)
  );

  logic aui_ff;
  logic tp_ff;
  logic nxt_aui;
  logic nxt_tp;
  // Auto mode prefers twisted pair while its link is good. The choice is
  // only made between frames so a running frame never changes port.
  // port decode
  always_comb begin
    nxt_aui = aui_ff;
    nxt_tp = tp_ff;
    if (!tx_busy && !carrier_ff) begin
      if (attachment_only_select) begin
        nxt_aui = 1'b1;
      end else if (!automatic_port_select) begin
        nxt_aui = 1'b0;
      end else begin
        nxt_aui = ~link_good_flag;
      end
      nxt_tp = ~nxt_aui;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aui_ff <= 1'b0;
      tp_ff <= 1'b0;
    end else begin
      aui_ff <= nxt_aui;
      tp_ff <= nxt_tp;
    end
  end

  assign aui_in_use = aui_ff;
  assign twisted_pair_in_use = tp_ff;
  assign tp_tx_enable = tp_ff;

  // ********************************************************************
  // Transmit and receive frame gates.
  // ********************************************************************
  ethlcs_pkg::ethlcs_gate_t tx_state_ff;
  ethlcs_pkg::ethlcs_gate_t nxt_tx_state;
  ethlcs_pkg::ethlcs_gate_t rx_state_ff;
  ethlcs_pkg::ethlcs_gate_t nxt_rx_state;
  assign tx_grant = (tx_state_ff == ethlcs_pkg::ETHLCS_GATE_IDLE) &
                    transmit_enable_bit & tx_request;
  assign tx_busy = (tx_state_ff == ethlcs_pkg::ETHLCS_GATE_BUSY);
  assign rx_pass = (rx_state_ff == ethlcs_pkg::ETHLCS_GATE_BUSY);

  // A frame in flight ignores the enable bit until its own end.
  // finish frame
  always_comb begin
    case (tx_state_ff)
      ethlcs_pkg::ETHLCS_GATE_IDLE: begin
        nxt_tx_state = tx_grant ? ethlcs_pkg::ETHLCS_GATE_BUSY : tx_state_ff;
      end
      ethlcs_pkg::ETHLCS_GATE_BUSY: begin
        nxt_tx_state = tx_frame_end ? ethlcs_pkg::ETHLCS_GATE_IDLE : tx_state_ff;
      end
      default: begin
        nxt_tx_state = ethlcs_pkg::ETHLCS_GATE_IDLE;
      end
    endcase
  end

  // A frame is admitted at its carrier rise and runs until carrier ends.
  // receive gate
  always_comb begin
    case (rx_state_ff)
      ethlcs_pkg::ETHLCS_GATE_IDLE: begin
        nxt_rx_state = (nxt_carrier && !carrier_ff && receive_enable_bit) ?
                       ethlcs_pkg::ETHLCS_GATE_BUSY : rx_state_ff;
      end
      ethlcs_pkg::ETHLCS_GATE_BUSY: begin
        nxt_rx_state = nxt_carrier ? rx_state_ff : ethlcs_pkg::ETHLCS_GATE_IDLE;
      end
      default: begin
        nxt_rx_state = ethlcs_pkg::ETHLCS_GATE_IDLE;
      end
    endcase
  end

  // Register both gates.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_state_ff <= ethlcs_pkg::ETHLCS_GATE_IDLE;
      rx_state_ff <= ethlcs_pkg::ETHLCS_GATE_IDLE;
    end else begin
      tx_state_ff <= nxt_tx_state;
      rx_state_ff <= nxt_rx_state;
    end
  end

  // ********************************************************************
  // Line status and read data.
  // ********************************************************************
  logic [15:0] status_word;
  logic [15:0] rdata_ff;
  logic [15:0] nxt_rdata;
  logic pol_ok_ff;
  // The status word is assembled from live flags; no write path reaches it.
  // status identity
  always_comb begin
    status_word = 16'h0000;
    status_word[ethlcs_pkg::CFG_ID_W-1:0] = ethlcs_pkg::LINE_STATUS_ID;
    status_word[ethlcs_pkg::STS_LINK_GOOD] = link_good_flag;
    status_word[ethlcs_pkg::STS_AUI] = aui_ff;
    status_word[ethlcs_pkg::STS_TP] = tp_ff;
    status_word[ethlcs_pkg::STS_POL_OK] = pol_ok_ff;
    status_word[ethlcs_pkg::STS_CRS] = carrier_ff;
  end

  // status write ignored
  // Only reads select the status word; unmapped reads return zero.
  always_comb begin
    nxt_rdata = rdata_ff;
    if (reg_rd) begin
      if (cfg_hit) begin
        nxt_rdata = config_ff;
      end else if (sts_hit) begin
        nxt_rdata = status_word;
      end else begin
        nxt_rdata = 16'h0000;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_ff <= 16'h0000;
      pol_ok_ff <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      pol_ok_ff <= ~pol_reversed;
    end
  end

  assign reg_rdata = rdata_ff;

endmodule
`default_nettype wire

// File: verification/ethlcs_medium.sv
// Behavioural network medium seen through the analogue front end pins.
// Assumes the bench calls its tasks; lines idle low between frames.
`timescale 1ns/10ps
`default_nettype none
module ethlcs_medium (
  // Pins toward the front end.
  output logic rx_data_pin,
  output logic link_pulse_pin,
  output logic rx_pol_reversed_pin
);
  // Quiet line with correct polarity until told otherwise.
  initial begin
    rx_data_pin = 1'b0;
    link_pulse_pin = 1'b0;
    rx_pol_reversed_pin = 1'b0;
  end

  // One rising transition per 100 ns bit, as recovered data at 10 Mb/s.
  task automatic send_frame(input int bits);
    repeat (bits) begin
      rx_data_pin = 1'b1;
      #50;
      rx_data_pin = 1'b0;
      #50;
    end
  endtask

  // A single link pulse, long enough for the three-flop synchroniser.
  task automatic link_pulse();
    link_pulse_pin = 1'b1;
    #100;
    link_pulse_pin = 1'b0;
  endtask

  // Swapped receive wires show up as a level on the polarity pin.
  task automatic set_reversed(input logic rev);
    rx_pol_reversed_pin = rev;
  endtask
endmodule
`default_nettype wire

// File: verification/ethlcs_checker.sv
// Port-level checks of the line control and status block.
// Assumes one clock domain; bound to every instance of the top module.
`timescale 1ns/10ps
`default_nettype none
module ethlcs_checker (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Register port.
  input wire logic [11:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  // Transmit gate.
  input wire logic tx_request,
  input wire logic tx_frame_end,
  input wire logic tx_grant,
  input wire logic tx_busy,
  // Controls and port state.
  input wire logic modified_backoff_enable,
  input wire logic two_part_defer_disable,
  input wire logic low_squelch_select,
  input wire logic aui_in_use,
  input wire logic twisted_pair_in_use,
  input wire logic tp_tx_enable
);
  // One domain, so clock and reset are given once for every check.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // A grant is never given without a request or while a frame runs.
  grant_needs_req_a: assert property (tx_grant |-> tx_request && !tx_busy)
    else $error("grant without request or while busy");
  busy_follows_a: assert property (tx_grant |=> tx_busy)
    else $error("grant did not start a frame");
  busy_holds_a: assert property (tx_busy && !tx_frame_end |=> tx_busy)
    else $error("frame dropped before its end");
  busy_ends_a: assert property (tx_busy && tx_frame_end |=> !tx_busy)
    else $error("busy stayed after frame end");
  // Ports are exclusive and the twisted pair driver follows its port.
  port_excl_a: assert property (aui_in_use |-> !twisted_pair_in_use)
    else $error("both ports in use");
  tp_driver_a: assert property (tp_tx_enable == twisted_pair_in_use)
    else $error("twisted pair driver does not follow port");
  // Status reads always carry the identification pattern.
  status_id_a: assert property (reg_rd && reg_addr == 12'h134 |=> reg_rdata[5:0] == 6'h14)
    else $error("status identification bits wrong");
  // Config writes reach the MAC and front end controls one cycle later.
  cfg_ctrl_a: assert property (reg_wr && reg_addr == 12'h112 |=>
    {low_squelch_select, two_part_defer_disable, modified_backoff_enable} ==
    {$past(reg_wdata[14]), $past(reg_wdata[13]), $past(reg_wdata[11])})
    else $error("config controls do not follow write");
endmodule

bind ethlcs_top ethlcs_checker i_chk (.clk, .rst_b, .reg_addr, .reg_wr, .reg_rd,
  .reg_wdata, .reg_rdata, .tx_request, .tx_frame_end, .tx_grant, .tx_busy,
  .modified_backoff_enable, .two_part_defer_disable, .low_squelch_select,
  .aui_in_use, .twisted_pair_in_use, .tp_tx_enable);
`default_nettype wire

// File: verification/tb_top.sv
// Self-checking bench of the line control and status block.
// Assumes the medium model on the pins and a shortened link timer.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk, rst_b, reg_wr, reg_rd, eeprom_load, tx_request, tx_frame_end;
  logic [11:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, eeprom_config;
  logic tx_grant, tx_busy, rx_pass, rx_data, rx_invert, aui_in_use, tp_tx_enable;
  logic modified_backoff_enable, two_part_defer_disable, low_squelch_select;
  logic twisted_pair_in_use, rx_data_pin, link_pulse_pin, rx_pol_reversed_pin;
  int n_fail, checked;
  localparam int LFAIL = 100;
  localparam logic [11:0] CFG = ethlcs_pkg::LINE_CONFIG_OFFSET;
  localparam logic [11:0] STS = ethlcs_pkg::LINE_STATUS_OFFSET;
  localparam logic [15:0] ST = ethlcs_pkg::LINE_STATUS_RESET;
  localparam logic [15:0] LNK = 16'h0001 << ethlcs_pkg::STS_LINK_GOOD;
  localparam logic [15:0] AUI = 16'h0001 << ethlcs_pkg::STS_AUI;
  localparam logic [15:0] TP = 16'h0001 << ethlcs_pkg::STS_TP;
  localparam logic [15:0] POL = 16'h0001 << ethlcs_pkg::STS_POL_OK;
  localparam logic [15:0] CARRIER_SENSE_FLAG = 16'h0001 << ethlcs_pkg::STS_CRS;

  // Short link timeout keeps the quiet-line cases within about a hundred cycles.
  ethlcs_top #(.LINK_FAIL_CYCLES(LFAIL)) i_dut (.clk, .rst_b, .reg_addr, .reg_wr,
    .reg_rd, .reg_wdata, .reg_rdata, .eeprom_load, .eeprom_config, .tx_request,
    .tx_frame_end, .tx_grant, .tx_busy, .rx_pass, .rx_data_pin, .link_pulse_pin,
    .rx_pol_reversed_pin, .rx_data, .rx_invert, .modified_backoff_enable,
    .two_part_defer_disable, .low_squelch_select, .aui_in_use, .twisted_pair_in_use,
    .tp_tx_enable);
  ethlcs_medium i_med (.rx_data_pin, .link_pulse_pin, .rx_pol_reversed_pin);

  // Free-running 200 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Inputs always move 1 ns after a rising edge.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // The strobe drops and one idle cycle passes, so calls may follow at once.
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [11:0] a, input logic [15:0] exp, input string what);
    reg_addr = a;
    reg_rd = 1'b1;
    cyc(1);
    reg_rd = 1'b0;
    chk(what, exp, reg_rdata);
    cyc(1);
  endtask
  task automatic stop_test();
    if (n_fail == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Config bits 5:0 cannot be written; status ignores host writes entirely.
  task automatic t_regs();
    rd(CFG, ethlcs_pkg::LINE_CONFIG_RESET, "config reset");
    rd(STS, ST | TP | POL, "status reset");
    wr(CFG, 16'h7bff);
    rd(CFG, 16'h7bd3, "config all");
    chk("controls", 16'h0007, {13'h0000, low_squelch_select, two_part_defer_disable,
      modified_backoff_enable});
    chk("tp driver", 16'h0000, {15'h0000, tp_tx_enable});
    wr(STS, 16'h0000);
    rd(STS, ST | AUI | POL, "status write");
    rd(12'h120, 16'h0000, "unmapped");
    wr(CFG, 16'h0000);
    chk("controls off", 16'h0000, {13'h0000, low_squelch_select,
      two_part_defer_disable, modified_backoff_enable});
  endtask

  // Every port decode, then auto select following link state.
  task automatic t_port();
    logic [15:0] mode [4] = '{16'h0000, 16'h0100, 16'h0300, 16'h0200};
    for (int i = 0; i < 4; i++) begin
      wr(CFG, mode[i]);
      chk("aui", {15'h0000, i != 0}, {15'h0000, aui_in_use});
      chk("tp", {15'h0000, i == 0}, {15'h0000, twisted_pair_in_use});
    end
    i_med.link_pulse();
    cyc(8);
    rd(STS, ST | LNK | TP | POL, "status link");
    cyc(LFAIL + 10);
    rd(STS, ST | AUI | POL, "status quiet");
  endtask

  // Refused while disabled and while busy; disable mid-frame finishes it.
  task automatic t_tx();
    wr(CFG, 16'h0000);
    tx_request = 1'b1;
    cyc(1);
    chk("grant off", 16'h0000, {15'h0000, tx_grant});
    wr(CFG, 16'h0080);
    chk("busy", 16'h0001, {15'h0000, tx_busy});
    chk("grant busy", 16'h0000, {15'h0000, tx_grant});
    wr(CFG, 16'h0000);
    chk("busy hold", 16'h0001, {15'h0000, tx_busy});
    tx_frame_end = 1'b1;
    cyc(1);
    tx_frame_end = 1'b0;
    chk("busy end", 16'h0000, {15'h0000, tx_busy});
    chk("no regrant", 16'h0000, {15'h0000, tx_grant});
    tx_request = 1'b0;
  endtask

  // Receive disabled after the frame started keeps it; the next is blocked.
  task automatic t_rx();
    wr(CFG, 16'h0040);
    i_med.send_frame(4);
    wr(CFG, 16'h0000);
    chk("rx pass", 16'h0001, {15'h0000, rx_pass});
    cyc(4);
    rd(STS, ST | LNK | TP | POL | CARRIER_SENSE_FLAG, "status carrier");
    cyc(16);
    rd(STS, ST | LNK | TP | POL, "status eof");
    chk("rx pass end", 16'h0000, {15'h0000, rx_pass});
    i_med.send_frame(2);
    chk("rx blocked", 16'h0000, {15'h0000, rx_pass});
  endtask

  // Polarity status follows the wire whether or not correction is on.
  task automatic t_pol();
    cyc(LFAIL + 20);
    wr(CFG, 16'h1000);
    i_med.set_reversed(1'b1);
    cyc(6);
    chk("no fix", 16'h0000, {14'h0000, rx_invert, rx_data});
    rd(STS, ST | TP, "status reversed");
    wr(CFG, 16'h0000);
    cyc(3);
    chk("fix", 16'h0003, {14'h0000, rx_invert, rx_data});
    rd(STS, ST | LNK | TP | CARRIER_SENSE_FLAG, "status fixed");
    i_med.set_reversed(1'b0);
  endtask

  task automatic t_eeprom();
    eeprom_config = 16'h4000;
    eeprom_load = 1'b1;
    cyc(1);
    eeprom_load = 1'b0;
    rd(CFG, 16'h4013, "eeprom config");
    chk("squelch", 16'h0001, {15'h0000, low_squelch_select});
  endtask

  // Main sequence: reset for three cycles, then each scenario in turn.
  initial begin
    n_fail = 0;
    checked = 0;
    rst_b = 1'b0;
    {reg_wr, reg_rd, eeprom_load, tx_request, tx_frame_end} = 5'h00;
    reg_addr = 12'h000;
    reg_wdata = 16'h0000;
    eeprom_config = 16'h0000;
    cyc(3);
    rst_b = 1'b1;
    cyc(1);
    t_regs();
    t_port();
    t_tx();
    t_rx();
    t_pol();
    t_eeprom();
    stop_test();
  end

  // The scenarios need about 470 cycles; a hang ends the run far later.
  initial begin
    #100000;
    n_fail++;
    stop_test();
  end
endmodule
`default_nettype wire
